// [include/serial_port_pkg.sv]
/*
 Shared constants, types and helpers of the serial host port.
 Assumes a single clk domain; pin levels arrive through a synchroniser.
*/
package serial_port_pkg;
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 24;
  localparam int NUM_REGS = 64;

  // SPI frame bit counts (rising edges seen so far)
  localparam logic [5:0] CNT_ADDR_END  = 6'h06;
  localparam logic [5:0] CNT_DATA_OUT  = 6'h08;
  localparam logic [5:0] CNT_FRAME_END = 6'h20;

  // I2C byte bit counts and upper address bits
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam logic [3:0] I2C_ACK_BIT   = 4'h9;
  localparam logic [1:0] I2C_LAST_BYTE = 2'h2;
  localparam logic [5:0] I2C_ADDR_HI   = 6'h04;

  // Cold start settle time before the strap is latched
  localparam logic [2:0] INIT_LAST = 3'h4;

  // Locations that hold storage; the rest read zero
  localparam logic [63:0] IMPL_MASK = 64'h00FF_FFFF_FFFF_FFFF;

  typedef enum logic [1:0] {
    P_INIT = 2'b00,
    P_SPI  = 2'b01,
    P_I2C  = 2'b10
  } port_mode_t;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_REG  = 3'b010,
    I_WR   = 3'b011,
    I_RD   = 3'b100
  } i2c_state_t;

  function automatic logic [7:0] byte_of(input logic [23:0] d,
                                         input logic [1:0]  i);
    byte_of = (i == 2'h0) ? d[23:16] : (i == 2'h1) ? d[15:8] : d[7:0];
  endfunction

  function automatic logic edge_up(input logic prev, input logic cur);
    edge_up = !prev && cur;
  endfunction
endpackage

// [include/regfile_if.sv]
/*
 Access path between the protocol engines and the register store.
 Assumes one clk; read data appear one cycle after rd_en.
*/
interface regfile_if;
  logic [5:0]  addr;
  logic        wr_en;
  logic [23:0] wdata;
  logic        rd_en;
  logic [23:0] rdata;

  modport host  (output addr, output wr_en, output wdata, output rd_en,
                 input rdata);
  modport store (input addr, input wr_en, input wdata, input rd_en,
                 output rdata);
endinterface

// [logic/pin_sync.sv]
/*
 Two flip-flop synchroniser for a group of pin levels.
 Assumes the inputs are asynchronous to clk.
*/
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// [logic/reg_store.sv]
/*
 Register map of 64 locations of 24 bits with registered read data.
 Assumes one access source at a time over regfile_if.
*/
module reg_store
  import serial_port_pkg::*;
#(
  parameter logic [63:0] IMPL = IMPL_MASK
) (
  input  wire logic clk,
  input  wire logic rst_b,
  regfile_if.store  m
);
  logic [23:0] mem_r [NUM_REGS];
  logic [23:0] rdata_r;

  assign m.rdata = rdata_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem_r[i] <= '0;
      end
    end else if (m.wr_en && IMPL[m.addr]) begin // [RULE17]
      mem_r[m.addr] <= m.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else if (m.rd_en) begin
      rdata_r <= IMPL[m.addr] ? mem_r[m.addr] : '0; // [RULE12] [RULE17]
    end
  end

  unimpl_read_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE17]
    m.rd_en && !IMPL[m.addr] |=> rdata_r == '0)
    else $error("Unimplemented location read nonzero");
endmodule

// [logic/pmic_serial_host_port.sv]
/*
 Host serial port: strap-selected SPI slave or I2C slave over four pins.
 Assumes clk much faster than the serial clock; pins are asynchronous.
*/
// Functional notes
// RULE1: Select pin low at cold start selects SPI.
// RULE2: Select pin high at cold start selects I2C slave.
// RULE3: Strap sampled once during init, held before the port is enabled.
// RULE4: Weak pull-down on select pin keeps an undriven pin in SPI.
// RULE5: SPI uses clock pin as clock, data-out as output, data-in as input.
// RULE6: After latching, select pin frames SPI transfers.
// RULE7: I2C uses clock pin as SCL and data-out pin as open-drain SDA.
// RULE8: In I2C, data-in strap picks one of two slave addresses.
// RULE9: In I2C, select pin is ignored after configuration.
// RULE10: Both protocols reach the same register set.
// RULE11: SPI frame: write flag, 6 address, null bit, 24 data bits.
// RULE12: Address decodes 64 locations of 24 bits, some unimplemented.
// RULE13: Flag one writes, zero reads; reads leave the register unchanged.
// RULE14: Sample on rising edges, drive 24 data bits MSB first on falling.
// RULE15: Write commits on 32nd falling edge; old contents shift out.
// RULE16: Select high for whole frame; short frames ignored; output off when low.
// RULE17: Unimplemented locations read zero and ignore writes.
module pmic_serial_host_port
  import serial_port_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic cs_pin,
  input  wire logic clk_pin,
  input  wire logic mosi_pin,
  input  wire logic miso_in,
  output logic      miso_out,
  output logic      miso_oe,
  output logic      cs_pulldown_en,
  output logic      i2c_mode
);
  import serial_port_pkg::*;

  regfile_if rf ();

  logic        cs_s;
  logic        sck_s;
  logic        mosi_s;
  logic        sda_s;
  logic        sck_p;
  logic        sda_p;
  port_mode_t  mode_r;
  logic [2:0]  init_cnt_r;
  logic        pulldown_r;
  logic        i2c_mode_r;
  logic        a0_r;
  logic [5:0]  cnt_r;
  logic        wnr_r;
  logic [23:0] in_sh_r;
  logic [5:0]  spi_addr_r;
  logic        spi_rd_r;
  logic        spi_wr_r;
  logic [23:0] out_sh_r;
  logic        spi_bit_r;
  i2c_state_t  ist_r;
  logic [3:0]  ibit_r;
  logic [7:0]  ish_r;
  logic        irw_r;
  logic        idrv_r;
  logic [5:0]  ireg_r;
  logic [1:0]  iidx_r;
  logic [23:0] iwbuf_r;
  logic [7:0]  ird_sh_r;
  logic        i_wr_r;
  logic        i_rd_r;
  logic        miso_out_r;
  logic        miso_oe_r;
  logic        sck_rise;
  logic        sck_fall;
  logic        i_start;
  logic        i_stop;
  logic [7:0]  next_byte;

  pin_sync #(.W(4)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({cs_pin, clk_pin, mosi_pin, miso_in}),
    .q     ({cs_s, sck_s, mosi_s, sda_s})
  );

  reg_store #(.IMPL(IMPL_MASK)) u_store (
    .clk   (clk),
    .rst_b (rst_b),
    .m     (rf.store)
  );

  assign sck_rise  = edge_up(sck_p, sck_s);
  assign sck_fall  = edge_up(sck_s, sck_p);
  assign i_start   = sck_s && sck_p && edge_up(sda_s, sda_p);
  assign i_stop    = sck_s && sck_p && edge_up(sda_p, sda_s);
  assign next_byte = byte_of(rf.rdata, iidx_r);

  assign miso_out       = miso_out_r;
  assign miso_oe        = miso_oe_r;
  assign cs_pulldown_en = pulldown_r;
  assign i2c_mode       = i2c_mode_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sck_p <= 1'b0;
      sda_p <= 1'b1;
    end else begin
      sck_p <= sck_s;
      sda_p <= sda_s;
    end
  end

  // Cold start strap latch
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_r     <= P_INIT;
      init_cnt_r <= '0;
      pulldown_r <= 1'b1; // [RULE4]
      i2c_mode_r <= 1'b0;
      a0_r       <= 1'b0;
    end else begin
      case (mode_r)
        P_INIT: begin
          if (init_cnt_r == INIT_LAST) begin // [RULE3]
            mode_r     <= cs_s ? P_I2C : P_SPI; // [RULE1] [RULE2]
            pulldown_r <= !cs_s; // [RULE4]
            i2c_mode_r <= cs_s;
            a0_r       <= mosi_s; // [RULE8]
          end else begin
            init_cnt_r <= init_cnt_r + 3'h1;
          end
        end
        P_SPI, P_I2C: mode_r <= mode_r;
        default: mode_r <= P_INIT;
      endcase
    end
  end

  // SPI receive side
  always_ff @(posedge clk) begin
    if (!rst_b || mode_r != P_SPI || !cs_s) begin // [RULE6] [RULE16]
      cnt_r      <= '0;
      wnr_r      <= 1'b0;
      in_sh_r    <= '0;
      spi_addr_r <= '0;
    end else if (sck_rise && cnt_r != CNT_FRAME_END) begin // [RULE14]
      cnt_r   <= cnt_r + 6'h01;
      in_sh_r <= {in_sh_r[22:0], mosi_s}; // [RULE5]
      if (cnt_r == '0) begin
        wnr_r <= mosi_s; // [RULE11] [RULE13]
      end
      if (cnt_r == CNT_ADDR_END) begin
        spi_addr_r <= {in_sh_r[4:0], mosi_s}; // [RULE11]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      spi_rd_r <= 1'b0;
      spi_wr_r <= 1'b0;
    end else begin
      spi_rd_r <= mode_r == P_SPI && cs_s && sck_rise
                  && cnt_r == CNT_ADDR_END;
      spi_wr_r <= mode_r == P_SPI && cs_s && sck_fall && wnr_r
                  && cnt_r == CNT_FRAME_END; // [RULE13] [RULE15]
    end
  end

  // SPI transmit side
  always_ff @(posedge clk) begin
    if (!rst_b || mode_r != P_SPI || !cs_s) begin
      out_sh_r  <= '0;
      spi_bit_r <= 1'b0;
    end else if (sck_fall && cnt_r == CNT_DATA_OUT) begin // [RULE14]
      spi_bit_r <= rf.rdata[23]; // [RULE15]
      out_sh_r  <= {rf.rdata[22:0], 1'b0};
    end else if (sck_fall && cnt_r > CNT_DATA_OUT
                 && cnt_r < CNT_FRAME_END) begin
      spi_bit_r <= out_sh_r[23];
      out_sh_r  <= {out_sh_r[22:0], 1'b0};
    end
  end

  // I2C slave
  always_ff @(posedge clk) begin
    if (!rst_b || mode_r != P_I2C || i_stop) begin // [RULE9]
      ist_r    <= I_IDLE;
      ibit_r   <= '0;
      ish_r    <= '0;
      irw_r    <= 1'b0;
      idrv_r   <= 1'b0;
      iidx_r   <= '0;
      ird_sh_r <= '0;
      i_wr_r   <= 1'b0;
      i_rd_r   <= 1'b0;
      if (!rst_b) begin
        ireg_r  <= '0;
        iwbuf_r <= '0;
      end
    end else begin
      i_wr_r <= 1'b0;
      i_rd_r <= 1'b0;
      if (i_start) begin
        ist_r  <= I_ADDR;
        ibit_r <= '0;
        idrv_r <= 1'b0;
        iidx_r <= '0;
      end else if (sck_rise) begin // [RULE7]
        ish_r <= {ish_r[6:0], sda_s};
        if (ibit_r != I2C_ACK_BIT) begin
          ibit_r <= ibit_r + 4'h1;
        end
      end else if (sck_fall && ist_r != I_IDLE) begin
        if (ibit_r == I2C_BYTE_BITS) begin
          case (ist_r)
            I_ADDR: begin
              if (ish_r[7:1] == {I2C_ADDR_HI, a0_r}) begin // [RULE8]
                idrv_r <= 1'b1;
                irw_r  <= ish_r[0];
                i_rd_r <= 1'b1;
              end else begin
                ist_r <= I_IDLE;
              end
            end
            I_REG: begin
              ireg_r <= ish_r[5:0]; // [RULE10]
              idrv_r <= 1'b1;
            end
            I_WR: begin
              iwbuf_r <= {iwbuf_r[15:0], ish_r};
              idrv_r  <= 1'b1;
              if (iidx_r == I2C_LAST_BYTE) begin
                i_wr_r <= 1'b1; // [RULE10]
                iidx_r <= '0;
              end else begin
                iidx_r <= iidx_r + 2'h1;
              end
            end
            default: idrv_r <= 1'b0;
          endcase
        end else if (ibit_r == I2C_ACK_BIT) begin
          ibit_r <= '0;
          idrv_r <= 1'b0;
          case (ist_r)
            I_ADDR: begin
              if (irw_r) begin
                ist_r    <= I_RD;
                idrv_r   <= !next_byte[7];
                ird_sh_r <= {next_byte[6:0], 1'b0};
                iidx_r   <= iidx_r + 2'h1;
              end else begin
                ist_r <= I_REG;
              end
            end
            I_REG: begin
              ist_r  <= I_WR;
              i_rd_r <= 1'b1;
            end
            I_WR: begin
              if (iidx_r == '0) begin
                ireg_r <= ireg_r + 6'h01;
              end
            end
            I_RD: begin
              if (ish_r[0]) begin
                ist_r <= I_IDLE;
              end else begin
                idrv_r   <= !next_byte[7];
                ird_sh_r <= {next_byte[6:0], 1'b0};
                if (iidx_r == I2C_LAST_BYTE) begin
                  iidx_r <= '0;
                  ireg_r <= ireg_r + 6'h01;
                  i_rd_r <= 1'b1;
                end else begin
                  iidx_r <= iidx_r + 2'h1;
                end
              end
            end
            default: ist_r <= I_IDLE;
          endcase
        end else if (ist_r == I_RD) begin
          idrv_r   <= !ird_sh_r[7];
          ird_sh_r <= {ird_sh_r[6:0], 1'b0};
        end
      end
    end
  end

  // Shared register path
  always_comb begin
    if (mode_r == P_I2C) begin // [RULE10]
      rf.addr  = ireg_r;
      rf.wr_en = i_wr_r;
      rf.wdata = iwbuf_r;
      rf.rd_en = i_rd_r;
    end else begin
      rf.addr  = spi_addr_r;
      rf.wr_en = spi_wr_r;
      rf.wdata = in_sh_r;
      rf.rd_en = spi_rd_r;
    end
  end

  // Data-out pin drive
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      miso_out_r <= 1'b0;
      miso_oe_r  <= 1'b0;
    end else if (mode_r == P_SPI) begin
      miso_out_r <= spi_bit_r; // [RULE5]
      miso_oe_r  <= cs_s; // [RULE16]
    end else if (mode_r == P_I2C) begin
      miso_out_r <= 1'b0; // [RULE7]
      miso_oe_r  <= idrv_r;
    end else begin
      miso_out_r <= 1'b0;
      miso_oe_r  <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence strap_due;
    mode_r == P_INIT && init_cnt_r == INIT_LAST;
  endsequence

  sequence data_start;
    mode_r == P_SPI && cs_s && sck_fall && cnt_r == CNT_DATA_OUT;
  endsequence

  spi_strap_a: assert property (strap_due and !cs_s |=> mode_r == P_SPI) // [RULE1]
    else $error("Low strap did not select SPI");

  i2c_strap_a: assert property (strap_due and cs_s |=> mode_r == P_I2C) // [RULE2]
    else $error("High strap did not select I2C");

  mode_hold_a: assert property (mode_r != P_INIT |=> $stable(mode_r)) // [RULE3]
    else $error("Protocol choice changed after latch");

  pulldown_mode_a: assert property (mode_r != P_INIT |-> pulldown_r == !i2c_mode_r) // [RULE4]
    else $error("Pull-down state disagrees with mode");

  miso_off_a: assert property (mode_r == P_SPI && !cs_s |=> !miso_oe_r) // [RULE16]
    else $error("Output driven while select low");

  msb_first_a: assert property (data_start |=> ##1 miso_out_r == $past(rf.rdata[23], 2)) // [RULE14]
    else $error("First data bit is not the MSB");

  write_commit_a: assert property (rf.wr_en && mode_r == P_SPI |-> wnr_r && cnt_r == CNT_FRAME_END) // [RULE13] [RULE15]
    else $error("SPI write outside a full write frame");

  commit_due_a: assert property (mode_r == P_SPI && cs_s && sck_fall && wnr_r && cnt_r == CNT_FRAME_END |=> rf.wr_en) // [RULE15]
    else $error("Write frame did not commit");

  cs_ignored_a: assert property (mode_r == P_I2C |-> cnt_r == '0 && !spi_wr_r) // [RULE9]
    else $error("SPI engine active in I2C mode");

  addr_ack_a: assert property (ist_r == I_ADDR && sck_fall && ibit_r == I2C_BYTE_BITS && ish_r[7:1] == {I2C_ADDR_HI, a0_r} && !i_start |=> ##1 miso_oe_r) // [RULE8]
    else $error("Own address not acknowledged");
endmodule

// [tb/host_model.sv]
/*
 Host master model: bit-banged SPI frames, I2C address probe and strap pins.
 Assumes the bench clk; pin changes land 1 ns after a clk edge.
*/
module host_model (
  input  wire logic clk,
  input  wire logic miso_lvl,
  output logic      cs_drv,
  output logic      cs_oe,
  output logic      sck,
  output logic      mosi,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_drv = 1'b0;
    cs_oe  = 1'b1;
    sck    = 1'b0;
    mosi   = 1'b0;
    sda_m  = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Half period of the 200 ns link clock
  task automatic half();
    wait_n(4);
  endtask

  // Strap levels; clock idles high only when lvl is high, even with select released
  task automatic strap(input logic drive, input logic lvl, input logic a0);
    cs_oe  = drive;
    cs_drv = lvl;
    mosi   = a0;
    sck    = lvl;
    sda_m  = 1'b1;
  endtask

  task automatic xfer(input logic wnr, input logic [5:0] a,
                      input logic [23:0] d, input int nbits,
                      output logic [23:0] q);
    logic [31:0] f;
    f = {wnr, a, 1'b0, d};
    q = '0;
    cs_drv = 1'b1;
    half();
    for (int i = 0; i < nbits; i++) begin
      mosi = f[31-i];
      half();
      sck = 1'b1;
      half();
      if (i >= 8) begin
        q = {q[22:0], miso_lvl};
      end
      sck = 1'b0;
    end
    wait_n(8);
    cs_drv = 1'b0;
    wait_n(8);
  endtask

  task automatic i2c_bit(input logic b, output logic seen);
    wait_n(2);
    sda_m = b;
    wait_n(2);
    sck = 1'b1;
    half();
    seen = miso_lvl;
    sck = 1'b0;
  endtask

  // Start: data falls while clock stands high
  task automatic i2c_start();
    sda_m = 1'b0;
    half();
    sck = 1'b0;
  endtask

  // Stop: data rises while clock stands high
  task automatic i2c_stop();
    wait_n(2);
    sda_m = 1'b0;
    wait_n(2);
    sck = 1'b1;
    half();
    sda_m = 1'b1;
    half();
  endtask

  // One byte out, eight levels back, then the ninth bit from mack
  task automatic i2c_byte(input logic [7:0] b, input logic mack,
                          output logic [7:0] r, output logic ack);
    logic s;
    r = '0;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], s);
      r = {r[6:0], s};
    end
    i2c_bit(mack, s);
    ack = !s;
  endtask

  task automatic i2c_probe(input logic [6:0] a, output logic ack);
    logic [7:0] r;
    i2c_start();
    i2c_byte({a, 1'b0}, 1'b1, r, ack);
    i2c_stop();
  endtask
endmodule

// [tb/tb.sv]
/*
 Self-checking bench of the serial host port: strap, SPI frames, I2C probe.
 Assumes host_model drives the pins; tri-stated SPI data reads back inverted.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst_b, cs_pin, clk_pin, mosi_pin, miso_in;
  logic        miso_out, miso_oe, cs_pulldown_en, i2c_mode;
  logic        cs_drv, cs_oe, sda_m, last_r, ack;
  logic [23:0] q;
  int          failures, total_checks;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial rst_b = 1'b0;
  initial last_r = 1'b0;
  always @(posedge clk) if (miso_oe) last_r <= miso_out;

  assign cs_pin  = cs_oe ? cs_drv : !cs_pulldown_en;
  assign miso_in = i2c_mode ? (sda_m & !miso_oe)
                            : (miso_oe ? miso_out : !last_r);

  host_model host_u (.clk(clk), .miso_lvl(miso_in), .cs_drv(cs_drv),
                     .cs_oe(cs_oe), .sck(clk_pin), .mosi(mosi_pin),
                     .sda_m(sda_m));

  pmic_serial_host_port dut_u (.clk(clk), .rst_b(rst_b), .cs_pin(cs_pin),
    .clk_pin(clk_pin), .mosi_pin(mosi_pin), .miso_in(miso_in),
    .miso_out(miso_out), .miso_oe(miso_oe),
    .cs_pulldown_en(cs_pulldown_en), .i2c_mode(i2c_mode));

  task automatic check(input string name, input logic [23:0] seen,
                       input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic drive, input logic lvl, input logic a0);
    rst_b = 1'b0;
    host_u.strap(drive, lvl, a0);
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    host_u.wait_n(12);
  endtask

  task automatic t_strap_spi();
    do_reset(1'b0, 1'b0, 1'b0);
    check("mode_released", i2c_mode, 24'h0);
    check("pulldown", cs_pulldown_en, 24'h1);
    do_reset(1'b1, 1'b0, 1'b0);
    check("mode_low", i2c_mode, 24'h0);
    check("oe_idle", miso_oe, 24'h0);
  endtask

  task automatic t_write_read();
    host_u.xfer(1'b1, 6'h05, 24'hA5_5A3C, 32, q);
    check("wr_old", q, 24'h0);
    host_u.xfer(1'b1, 6'h05, 24'h12_3456, 32, q);
    check("wr_back", q, 24'hA5_5A3C);
    host_u.xfer(1'b0, 6'h05, 24'hFF_FFFF, 32, q);
    check("rd_data", q, 24'h12_3456);
    host_u.xfer(1'b0, 6'h05, 24'h0, 32, q);
    check("rd_keep", q, 24'h12_3456);
    check("oe_after", miso_oe, 24'h0);
  endtask

  task automatic t_abort();
    host_u.xfer(1'b1, 6'h05, 24'h0F_0F0F, 20, q);
    host_u.xfer(1'b1, 6'h05, 24'h0F_0F0F, 31, q);
    host_u.xfer(1'b0, 6'h05, 24'h0, 32, q);
    check("abort", q, 24'h12_3456);
  endtask

  task automatic t_map_edges();
    logic [5:0]  a;
    logic [23:0] pat;
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 6'h00 : (i == 1) ? 6'h37 : (i == 2) ? 6'h38 : 6'h3F;
      pat = {18'h3_0C3C, a};
      host_u.xfer(1'b1, a, pat, 32, q);
      host_u.xfer(1'b0, a, 24'h0, 32, q);
      check("map", q, serial_port_pkg::IMPL_MASK[a] ? pat : 24'h0);
    end
    host_u.xfer(1'b0, 6'h05, 24'h0, 32, q);
    check("no_alias", q, 24'h12_3456);
  endtask

  task automatic t_i2c();
    do_reset(1'b1, 1'b1, 1'b1);
    check("mode_i2c", i2c_mode, 24'h1);
    check("pd_off", cs_pulldown_en, 24'h0);
    check("oe_cs_hi", miso_oe, 24'h0);
    host_u.cs_drv = 1'b0;
    host_u.wait_n(8);
    check("mode_held", i2c_mode, 24'h1);
    host_u.i2c_probe({serial_port_pkg::I2C_ADDR_HI, 1'b1}, ack);
    check("ack_own", ack, 24'h1);
    host_u.i2c_probe({serial_port_pkg::I2C_ADDR_HI, 1'b0}, ack);
    check("ack_other", ack, 24'h0);
  endtask

  task automatic t_i2c_rw();
    logic [7:0] r0, r1, r2;
    logic       a;
    host_u.i2c_start();
    host_u.i2c_byte({serial_port_pkg::I2C_ADDR_HI, 2'b10}, 1'b1, r0, a);
    host_u.i2c_byte(8'h05, 1'b1, r0, a);
    host_u.i2c_byte(8'h5A, 1'b1, r0, a);
    host_u.i2c_byte(8'hC3, 1'b1, r0, a);
    host_u.i2c_byte(8'hE1, 1'b1, r0, a);
    check("i2c_wr_ack", a, 24'h1);
    host_u.i2c_stop();
    host_u.i2c_start();
    host_u.i2c_byte({serial_port_pkg::I2C_ADDR_HI, 2'b10}, 1'b1, r0, a);
    host_u.i2c_byte(8'h05, 1'b1, r0, a);
    host_u.i2c_stop();
    host_u.i2c_start();
    host_u.i2c_byte({serial_port_pkg::I2C_ADDR_HI, 2'b11}, 1'b1, r0, a);
    host_u.i2c_byte(8'hFF, 1'b0, r0, a);
    host_u.i2c_byte(8'hFF, 1'b0, r1, a);
    host_u.i2c_byte(8'hFF, 1'b1, r2, a);
    host_u.i2c_stop();
    check("i2c_rd", {r0, r1, r2}, 24'h5A_C3E1);
  endtask

  initial begin
    failures = 0;
    total_checks = 0;
    t_strap_spi();
    t_write_read();
    t_abort();
    t_map_edges();
    t_i2c();
    t_i2c_rw();
    wrap_up();
  end

  // Run needs about 150 us
  initial begin
    #1_000_000;
    failures++;
    wrap_up();
  end
endmodule
